//--- common/curs_pkg.sv
// Shared constants and types of the clock unlock and reset sequencer.
package curs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets on the plain register port.
   localparam logic [3:0] OSC_CTRL_OFFSET    = 4'h0;   // Oscillator control.
   localparam logic [3:0] RESET_CAUSE_OFFSET = 4'h1;   // Reset cause flags.

   ////////////////////////////////////////////////////////////////////////////
   // Field positions in the oscillator control register.
   localparam int OSC_SWITCH_ENABLE_BIT   = 0;    // Switch enable.
   localparam int CF_BIT      = 3;    // Clock fail flag.
   localparam int LOCK_BIT    = 5;    // PLL lock status.
   localparam int NEW_OSC_LSB = 8;    // New oscillator group, two bits.
   localparam int CUR_OSC_LSB = 12;   // Current oscillator group, two bits.

   // Field positions in the reset cause register.
   localparam int POR_FLAG_BIT = 0;   // Power-on reset seen.
   localparam int BOR_FLAG_BIT = 1;   // Brown-out reset seen.

   ////////////////////////////////////////////////////////////////////////////
   // Unlock keys for the two bytes of the oscillator control register.
   localparam logic [7:0] LO_KEY1 = 8'h46;
   localparam logic [7:0] LO_KEY2 = 8'h57;
   localparam logic [7:0] HI_KEY1 = 8'h78;
   localparam logic [7:0] HI_KEY2 = 8'h9a;

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator group codes.
   localparam logic [1:0] GRP_LOW_POWER_INTERNAL_RC      = 2'h0;   // Low power internal RC.
   localparam logic [1:0] GRP_FRC       = 2'h1;   // Fast internal RC.
   localparam logic [1:0] GRP_SECONDARY = 2'h2;   // Secondary crystal.
   localparam logic [1:0] GRP_PRIMARY   = 2'h3;   // Primary oscillator.

   // Primary oscillator mode bits: crystal type and PLL use.
   localparam int PRI_CRYSTAL_BIT = 2;
   localparam int PRI_PLL_BIT     = 3;

   // Switch and monitor settings; any code with the top bit set disables both.
   localparam logic [1:0] SWM_BOTH_ON  = 2'h0;   // Switching and monitor on.
   localparam logic [1:0] SWM_SW_ONLY  = 2'h1;   // Switching on, monitor off.

   ////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [1:0] RESET_CAUSE_RESET = 2'h1;   // Power-on flag set.

   ////////////////////////////////////////////////////////////////////////////
   // Timing, clock 100 MHz.
   localparam int CLK_PERIOD_NS       = 10;
   localparam int POWER_ON_TIMEOUT_NS = 10000;
   localparam int POWER_UP_TIMEOUT_NS = 40000;
   localparam int FAIL_SAFE_DELAY_US  = 100;
   localparam int OST_CYCLES          = 1024;
   localparam int POWER_ON_CYCLES     = POWER_ON_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int POWER_UP_CYCLES     = POWER_UP_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int FAIL_SAFE_CYCLES    =
      (FAIL_SAFE_DELAY_US * 1000) / CLK_PERIOD_NS;
   localparam int CNT_W               = 24;       // Width of the counters.

   // Steps of the reset release sequence.
   typedef enum logic [2:0] {
      ST_POR,     // Power-on timeout running.
      ST_POWER_UP_TIMER,    // Power-up or fail-safe delay running.
      ST_OSC,     // Waiting for the oscillator holds.
      ST_RUN,     // Internal reset released.
      ST_BOR      // Brown-out in progress.
   } curs_seq_type;

endpackage : curs_pkg

//--- design/curs_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps

module curs_sync #(
   parameter int WIDTH = 1                  // Number of bits to carry.
) (
   input  wire logic             i_clk,     // System clock.
   input  wire logic             i_reset_n, // Asynchronous reset, low.
   input  wire logic [WIDTH-1:0] i_async,   // Levels from outside.
   output logic      [WIDTH-1:0] o_sync     // Levels in the clock domain.
);

   // Both stages kept in one state record.
   typedef struct packed {
      logic [WIDTH-1:0] s1;   // First stage, read only by the second.
      logic [WIDTH-1:0] s2;   // Second stage, safe to use.
   } curs_sync_state_type;

   curs_sync_state_type st;        // Current state.
   curs_sync_state_type next_st;   // Next state.

   ////////////////////////////////////////////////////////////////////////////
   // Shift the input through the two stages.
   always_comb begin
      next_st    = st;
      next_st.s1 = i_async;
      next_st.s2 = st.s1;
   end

   // Register the stages.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_sync = st.s2;

endmodule // curs_sync

//--- design/curs_top.sv
// Oscillator control unlock and reset release sequencer.
`timescale 1ns/1ps

module curs_top
   import curs_pkg::*;
#(
   parameter int unsigned P_POWER_ON_CYCLES  = curs_pkg::POWER_ON_CYCLES,
   parameter int unsigned P_POWER_UP_CYCLES  = curs_pkg::POWER_UP_CYCLES,
   parameter int unsigned P_FAIL_SAFE_CYCLES = curs_pkg::FAIL_SAFE_CYCLES,
   parameter int unsigned P_OST_CYCLES       = curs_pkg::OST_CYCLES
) (
   input  wire logic        i_clk,             // System clock, 100 MHz.
   input  wire logic        i_reset_n,         // Power-on reset, low.
   input  wire logic [3:0]  i_addr,            // Register address.
   input  wire logic [15:0] i_wr_data,         // Register write data.
   input  wire logic [1:0]  i_wr_be,           // Byte enables of a write.
   input  wire logic        i_wr,              // Write strobe.
   input  wire logic        i_rd,              // Read strobe.
   output logic      [15:0] o_rd_data,         // Read data, next cycle.
   input  wire logic [1:0]  i_osc_group_config,   // Start-up group.
   input  wire logic [3:0]  i_primary_osc_config, // Primary mode.
   input  wire logic [1:0]  i_switch_monitor_config, // Switch, monitor.
   input  wire logic        i_power_up_timer_en,  // Power-up timer on.
   input  wire logic        i_brownout_en,        // Brown-out detect on.
   input  wire logic [1:0]  i_brownout_trip_sel,  // Trip point select.
   input  wire logic [2:0]  i_supply_below,    // Comparators, one per trip.
   input  wire logic        i_osc_running,     // Oscillator is running.
   input  wire logic        i_pll_lock,        // PLL reports lock.
   output logic             o_internal_reset_n,   // Device reset, low.
   output logic             o_sys_clk_hold,    // System clock held.
   output logic [1:0]       o_cur_osc,         // Group in effect.
   output logic             o_clock_fail_trap, // Clock failure pulse.
   output logic             o_brownout_reset   // Brown-out reset pulse.
);

   ////////////////////////////////////////////////////////////////////////////
   // Refuse counts that the counters cannot hold.
   if (P_POWER_ON_CYCLES < 1 || P_POWER_ON_CYCLES >= (1 << CNT_W) ||
       P_POWER_UP_CYCLES < 1 || P_POWER_UP_CYCLES >= (1 << CNT_W) ||
       P_FAIL_SAFE_CYCLES < 1 || P_FAIL_SAFE_CYCLES >= (1 << CNT_W) ||
       P_OST_CYCLES < 1 || P_OST_CYCLES >= (1 << CNT_W)) begin : g_bad
      $error("curs_top: a timing count is out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // All state of the block in one record.
   typedef struct packed {
      curs_seq_type     seq;        // Reset release step.
      logic [CNT_W-1:0] cnt;        // Step timer.
      logic [CNT_W-1:0] ost_cnt;    // Oscillator start-up timer.
      logic             lo_key;     // First low byte key just seen.
      logic             hi_key;     // First high byte key just seen.
      logic             lo_open;    // Low byte writable this cycle.
      logic             hi_open;    // High byte writable this cycle.
      logic [1:0]       cur_osc;    // Current oscillator group.
      logic [1:0]       new_osc;    // Requested oscillator group.
      logic             cf;         // Clock fail flag.
      logic             osc_switch_enable;      // Oscillator switch enable.
      logic             por_flag;   // Power-on reset cause.
      logic             bor_flag;   // Brown-out reset cause.
      logic             trap;       // Clock failure trap pulse.
      logic             bor_pulse;  // Brown-out reset pulse.
      logic             rst_n;      // Internal reset, low.
      logic             clk_hold;   // System clock held.
      logic [15:0]      rd_data;    // Registered read data.
   } curs_state_type;

   curs_state_type st;        // Current state.
   curs_state_type next_st;   // Next state.

   logic [2:0] below_s;       // Synchronised comparator outputs.
   logic       osc_run_s;     // Synchronised oscillator running.
   logic       pll_lock_s;    // Synchronised PLL lock.

   // Analog and oscillator levels come from outside the clock domain.
   curs_sync #(
      .WIDTH (5)
   ) u_sync (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_async   ({i_supply_below, i_osc_running, i_pll_lock}),
      .o_sync    ({below_s, osc_run_s, pll_lock_s})
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decoded conditions used by the sequence and the registers.
   logic             monitor_en;  // Clock fail monitor active.
   logic             switch_en;   // Clock switching active.
   logic             crystal;     // Selected source needs start-up timer.
   logic             pll_used;    // Selected source goes through the PLL.
   logic             running_ok;  // Selected source is running.
   logic             holds_done;  // All oscillator holds met.
   logic             brownout;    // Supply under the selected trip.
   logic [CNT_W-1:0] pwr_delay;   // Length of the power-up step.
   logic             wr_osc;      // Write to oscillator control.
   logic [15:0]      osc_view;    // Read view of oscillator control.

   // Monitor and switching decode; the top bit set turns both off.
   always_comb begin
      monitor_en = (i_switch_monitor_config == SWM_BOTH_ON);
      switch_en  = monitor_en ||
                   (i_switch_monitor_config == SWM_SW_ONLY);
   end

   // Source type of the current group, taken from the configuration.
   always_comb begin
      crystal  = (st.cur_osc == GRP_SECONDARY) ||
                 ((st.cur_osc == GRP_PRIMARY) &&
                  i_primary_osc_config[PRI_CRYSTAL_BIT]);
      pll_used = (st.cur_osc == GRP_PRIMARY) &&
                 i_primary_osc_config[PRI_PLL_BIT];
      // RC and external clock sources run at once.
      running_ok = !crystal || osc_run_s;
      holds_done = running_ok &&
                   (!crystal ||
                    (st.ost_cnt >= CNT_W'(P_OST_CYCLES))) &&
                   (!pll_used || pll_lock_s);
   end

   // Trip point select; detection ignores sleep and idle entirely.
   always_comb begin
      case (i_brownout_trip_sel)
         2'h0:    brownout = below_s[0];
         2'h1:    brownout = below_s[1];
         default: brownout = below_s[2];
      endcase
      brownout = brownout && i_brownout_en;
   end

   // Power-up step length: timer, fail-safe delay or none.
   always_comb begin
      if (i_power_up_timer_en) begin
         pwr_delay = CNT_W'(P_POWER_UP_CYCLES);
      end else if (crystal && monitor_en) begin
         pwr_delay = CNT_W'(P_FAIL_SAFE_CYCLES);
      end else begin
         pwr_delay = '0;
      end
   end

   // Register view and write decode.
   always_comb begin
      wr_osc   = i_wr && (i_addr == OSC_CTRL_OFFSET);
      osc_view = '0;
      osc_view[CUR_OSC_LSB +: 2] = st.cur_osc;
      osc_view[NEW_OSC_LSB +: 2] = st.new_osc;
      osc_view[LOCK_BIT]         = pll_lock_s;
      osc_view[CF_BIT]           = st.cf;
      osc_view[OSC_SWITCH_ENABLE_BIT]        = st.osc_switch_enable;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state: unlock keys, register writes and the reset sequence.
   always_comb begin
      next_st           = st;
      next_st.trap      = 1'b0;
      next_st.bor_pulse = 1'b0;
      next_st.rd_data   = '0;

      // Key detection; a key must follow its partner in the next cycle.
      next_st.lo_key  = wr_osc && i_wr_be[0] &&
                        (i_wr_data[7:0] == LO_KEY1);
      next_st.hi_key  = wr_osc && i_wr_be[1] &&
                        (i_wr_data[15:8] == HI_KEY1);
      next_st.lo_open = st.lo_key && wr_osc && i_wr_be[0] &&
                        (i_wr_data[7:0] == LO_KEY2);
      next_st.hi_open = st.hi_key && wr_osc && i_wr_be[1] &&
                        (i_wr_data[15:8] == HI_KEY2);

      // Low byte write taken only in its open cycle.
      if (wr_osc && i_wr_be[0] && st.lo_open) begin
         next_st.osc_switch_enable = i_wr_data[OSC_SWITCH_ENABLE_BIT];
         next_st.cf    = st.cf && i_wr_data[CF_BIT];
      end
      // High byte write taken only in its open cycle.
      if (wr_osc && i_wr_be[1] && st.hi_open) begin
         next_st.new_osc = i_wr_data[NEW_OSC_LSB +: 2];
      end

      // A requested switch completes in one cycle when allowed.
      if (st.osc_switch_enable && st.seq == ST_RUN) begin
         if (switch_en) begin
            next_st.cur_osc = st.new_osc;
         end
         next_st.osc_switch_enable = 1'b0;
      end

      // Reset cause flags are cleared by writing zero.
      if (i_wr && i_addr == RESET_CAUSE_OFFSET && i_wr_be[0]) begin
         next_st.por_flag = st.por_flag && i_wr_data[POR_FLAG_BIT];
         next_st.bor_flag = st.bor_flag && i_wr_data[BOR_FLAG_BIT];
      end

      // Registered read answer, zero for unmapped addresses.
      if (i_rd) begin
         case (i_addr)
            OSC_CTRL_OFFSET:    next_st.rd_data = osc_view;
            RESET_CAUSE_OFFSET: next_st.rd_data =
                                   {14'h0, st.bor_flag, st.por_flag};
            default:            next_st.rd_data = '0;
         endcase
      end

      // Start-up timer counts oscillator activity from reset on.
      if (osc_run_s && st.ost_cnt < CNT_W'(P_OST_CYCLES)) begin
         next_st.ost_cnt = st.ost_cnt + CNT_W'(1);
      end

      case (st.seq)
         ST_POR: begin
            // Groups follow the configuration while in reset.
            next_st.cur_osc = i_osc_group_config;
            next_st.new_osc = i_osc_group_config;
            next_st.cnt     = st.cnt + CNT_W'(1);
            if (st.cnt == CNT_W'(P_POWER_ON_CYCLES - 1)) begin
               next_st.cnt = '0;
               next_st.seq = (pwr_delay == '0) ? ST_OSC : ST_POWER_UP_TIMER;
            end
         end
         ST_POWER_UP_TIMER: begin
            next_st.cnt = st.cnt + CNT_W'(1);
            if (st.cnt == pwr_delay - CNT_W'(1)) begin
               next_st.cnt = '0;
               next_st.seq = ST_OSC;
            end
         end
         ST_OSC: begin
            if (holds_done) begin
               next_st.seq      = ST_RUN;
               next_st.rst_n    = 1'b1;
               next_st.clk_hold = 1'b0;
            end else if (monitor_en) begin
               // Give up on the slow source and run from fast RC.
               next_st.trap     = 1'b1;
               next_st.cur_osc  = GRP_FRC;
               next_st.cf       = 1'b1;
               next_st.osc_switch_enable    = 1'b0;
               next_st.seq      = ST_RUN;
               next_st.rst_n    = 1'b1;
               next_st.clk_hold = 1'b0;
            end
            // Without the monitor the device stays frozen here.
         end
         ST_RUN: begin
            next_st.rst_n = 1'b1;
         end
         ST_BOR: begin
            next_st.cur_osc = i_osc_group_config;
            next_st.new_osc = i_osc_group_config;
            if (!brownout) begin
               next_st.seq = ST_POR;
               next_st.cnt = '0;
            end
         end
         default: begin
            next_st.seq = ST_POR;
         end
      endcase

      // Brown-out overrides everything and restarts the sequence.
      if (brownout && st.seq != ST_BOR) begin
         next_st.seq       = ST_BOR;
         next_st.bor_pulse = 1'b1;
         next_st.bor_flag  = 1'b1;
         next_st.rst_n     = 1'b0;
         next_st.clk_hold  = 1'b1;
         next_st.ost_cnt   = '0;
         next_st.cnt       = '0;
         next_st.trap      = 1'b0;
      end
   end

   // Register the whole state.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st          <= '0;
         st.seq      <= ST_POR;
         st.cur_osc  <= GRP_FRC;
         st.new_osc  <= GRP_FRC;
         st.por_flag <= RESET_CAUSE_RESET[POR_FLAG_BIT];
         st.bor_flag <= RESET_CAUSE_RESET[BOR_FLAG_BIT];
         st.clk_hold <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign o_rd_data          = st.rd_data;
   assign o_internal_reset_n = st.rst_n;
   assign o_sys_clk_hold     = st.clk_hold;
   assign o_cur_osc          = st.cur_osc;
   assign o_clock_fail_trap  = st.trap;
   assign o_brownout_reset   = st.bor_pulse;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the behaviour.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_lo_unlock_seq: assert property (
      (wr_osc && i_wr_be[0] && i_wr_data[7:0] == LO_KEY1) ##1
      (wr_osc && i_wr_be[0] && i_wr_data[7:0] == LO_KEY2) |=> st.lo_open)
      else $error("low byte did not unlock after its keys");

   a_hi_unlock_seq: assert property (
      (wr_osc && i_wr_be[1] && i_wr_data[15:8] == HI_KEY1) ##1
      (wr_osc && i_wr_be[1] && i_wr_data[15:8] == HI_KEY2) |=> st.hi_open)
      else $error("high byte did not unlock after its keys");

   a_window_one_cycle: assert property (
      st.lo_open |=> !st.lo_open)
      else $error("low byte window lasted more than one cycle");

   a_locked_high_hold: assert property (
      (st.seq == ST_RUN && !st.hi_open && !brownout) |=>
      $stable(st.new_osc))
      else $error("locked high byte changed");

   a_trap_to_frc: assert property (
      $rose(st.trap) |-> st.cur_osc == GRP_FRC && st.cf && !st.osc_switch_enable &&
      st.rst_n)
      else $error("clock fail trap did not switch to fast RC");

   a_frozen_no_clock: assert property (
      (st.seq == ST_OSC && !monitor_en && !running_ok) |=> !st.rst_n)
      else $error("reset released without a running clock");

   a_brownout_reset: assert property (
      (brownout && st.seq != ST_BOR) |=>
      st.bor_pulse && !st.rst_n && st.bor_flag ##1 !st.bor_pulse)
      else $error("brown-out did not give a one cycle reset pulse");

   a_release_after_holds: assert property (
      $rose(st.rst_n) |-> $past(st.seq) == ST_OSC)
      else $error("internal reset released outside the oscillator step");

   a_clock_hold_ost: assert property (
      (!st.clk_hold && !st.trap && crystal && st.seq == ST_RUN &&
       $past(st.seq) == ST_OSC) |-> $past(st.ost_cnt) >=
      CNT_W'(P_OST_CYCLES))
      else $error("clock released before start-up timer expired");

   c_unlock_low: cover property (st.lo_open && wr_osc && i_wr_be[0]);
   c_clock_trap: cover property ($rose(st.trap));
   c_brownout:   cover property (st.bor_pulse ##[1:50] st.seq == ST_POR);
   c_release:    cover property ($rose(st.rst_n) && !st.cf);

endmodule // curs_top

//--- verif/test_curs_top.sv
// Self-checking bench of the clock unlock and reset sequencer.
`timescale 1ns/1ps
module test_curs_top;
   import curs_pkg::*;
   logic        clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, run = 1;
   logic [3:0]  addr = 4'h0, pri = 4'h0;
   logic [15:0] wd = 16'h0, rdat, v;
   logic [1:0]  be = 2'h0, grp = 2'h1, swm = 2'h2, cur;
   logic [2:0]  below = 3'h0;
   logic        irn, hold, trap, bor;
   logic        power_up_timer = 1, boren = 1, pll = 1;
   logic [1:0]  trip = 2'h1;
   int          n_mismatch = 0, checked = 0;
   always #5 clk = ~clk;
   curs_top #(.P_POWER_ON_CYCLES(10), .P_POWER_UP_CYCLES(20),
      .P_FAIL_SAFE_CYCLES(30), .P_OST_CYCLES(16)) dut_u (
      .i_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wr_data(wd),
      .i_wr_be(be), .i_wr(wr_s), .i_rd(rd_s), .o_rd_data(rdat),
      .i_osc_group_config(grp), .i_primary_osc_config(pri),
      .i_switch_monitor_config(swm), .i_power_up_timer_en(power_up_timer),
      .i_brownout_en(boren), .i_brownout_trip_sel(trip),
      .i_supply_below(below), .i_osc_running(run), .i_pll_lock(pll),
      .o_internal_reset_n(irn), .o_sys_clk_hold(hold), .o_cur_osc(cur),
      .o_clock_fail_trap(trap), .o_brownout_reset(bor));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Bounded wait for a design output to go high, sampled after the edge.
   task automatic wait_hi(ref logic s, input int n);
      for (int k = 0; k < n && s !== 1'b1; k++) @(posedge clk) #1;
      if (s !== 1'b1) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask
   // Write strobe stays up so writes may follow back to back.
   task automatic wr(input logic [1:0] b, input logic [15:0] d);
      @(posedge clk);
      {wr_s, rd_s, addr, be, wd} <= {2'b10, 4'h0, b, d};
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      {wr_s, rd_s, addr} <= {2'b01, a};
      @(posedge clk) rd_s <= 0;
      #1 d = rdat;
   endtask
   task automatic rst(input logic [1:0] g, input logic [3:0] p,
                      input logic [1:0] m, input logic r);
      @(posedge clk) {rst_n, wr_s, grp, pri, swm, run} <= {2'b00, g, p, m, r};
      repeat (2) @(posedge clk);
      rst_n <= 1;
   endtask
   initial begin
      rst(2'h1, 4'h0, 2'h2, 1'b1);
      repeat (28) @(posedge clk);
      #1 chk(16'(irn), 16'h0);
      chk(16'(cur), 16'h1);
      wait_hi(irn, 40);
      chk(16'(hold), 16'h0);
      wr(2'h2, 16'h7800); wr(2'h2, 16'h9a00); wr(2'h2, 16'h0200);
      wr(2'h2, 16'h7800); wr(2'h2, 16'h9a00); rd(0, v); wr(2'h2, 16'h0300);
      rd(0, v);
      chk(v & 16'h0300, 16'h0200);
      @(posedge clk) below <= 3'h2;
      wait_hi(bor, 6);
      chk(16'(irn), 16'h0);
      @(posedge clk) below <= 3'h0;
      wait_hi(irn, 80);
      rd(1, v);
      chk(v & 16'h0003, 16'h0003);
      rst(2'h3, 4'h4, 2'h0, 1'b0);
      wait_hi(trap, 80);
      #1 chk(16'(cur), 16'h1);
      rd(0, v);
      chk(v & 16'h3009, 16'h1008);
      wr(2'h1, 16'h0046); rd(0, v); wr(2'h1, 16'h0000); rd(0, v);
      chk(v & 16'h0008, 16'h0008);
      wr(2'h1, 16'h0046); wr(2'h1, 16'h0057); wr(2'h1, 16'h0000); rd(0, v);
      chk(v & 16'h0008, 16'h0000);
      // Monitor and power-up timer off: only the power-on timeout applies.
      @(posedge clk) power_up_timer <= 1'b0;
      rst(2'h1, 4'h0, 2'h2, 1'b1);
      repeat (10) @(posedge clk);
      #1 chk(16'(irn), 16'h0);
      @(posedge clk) #1 chk(16'(irn), 16'h1);
      // PLL source without lock and no monitor stays frozen in reset.
      @(posedge clk) pll <= 1'b0;
      rst(2'h3, 4'h8, 2'h2, 1'b1);
      repeat (20) @(posedge clk);
      #1 chk(16'(irn), 16'h0);
      chk(16'(cur), 16'h3);
      @(posedge clk) pll <= 1'b1;
      wait_hi(irn, 6);
      // Only the selected trip comparator may cause a brown-out.
      @(posedge clk) {trip, below} <= {2'h2, 3'h2};
      repeat (5) @(posedge clk);
      #1 chk(16'(irn), 16'h1);
      @(posedge clk) below <= 3'h4;
      wait_hi(bor, 6);
      chk(16'(irn), 16'h0);
      tally_and_finish();
   end
endmodule // test_curs_top
